// >>> fbmc_consts.vh
// Constants for the host-side parallel flash bus controller.
// Assumes a byte-wide flash with a 19-bit address and a 100 MHz core clock.
`ifndef FBMC_CONSTS_VH
`define FBMC_CONSTS_VH

// Clock period in ns.
`define FBMC_CLK_NS 10
// Bus cycle timing figures in ns.
`define FBMC_ACCESS_NS 70
`define FBMC_WRITE_PULSE_NS 35
`define FBMC_SETUP_NS 10
// Reset pulse and release-to-read times in ns.
`define FBMC_RESET_PULSE_MIN_NS 500
`define FBMC_RESET_RELEASE_TO_READ_NS 50
// Counts derived from the figures, rounded up; a zero figure gives zero cycles.
`define FBMC_CYC(ns) (((ns) + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)

// Command addresses, decoded on the low twelve address bits.
`define FBMC_UNLOCK_ADDR1 12'h555
`define FBMC_UNLOCK_ADDR2 12'h2aa
// Command data bytes.
`define FBMC_UNLOCK_DATA1 8'haa
`define FBMC_UNLOCK_DATA2 8'h55
`define FBMC_CMD_ID 8'h90
`define FBMC_CMD_PROGRAM 8'ha0
`define FBMC_CMD_ERASE_SETUP 8'h80
`define FBMC_CMD_CHIP_ERASE 8'h10
`define FBMC_CMD_SECTOR_ERASE 8'h30
`define FBMC_CMD_RESET 8'hf0
// Identification read addresses.
`define FBMC_ID_MAKER_ADDR 19'h00000
`define FBMC_ID_DEVICE_ADDR 19'h00001

// Operation codes on the user request port.
`define FBMC_OP_READ 3'h0
`define FBMC_OP_PROGRAM 3'h1
`define FBMC_OP_SECTOR_ERASE 3'h2
`define FBMC_OP_CHIP_ERASE 3'h3
`define FBMC_OP_ID_READ 3'h4
`define FBMC_OP_RESET_CMD 3'h5
`define FBMC_OP_HW_RESET 3'h6

`endif

// >>> fbmc_flash_host.v
// Host controller that drives a byte-wide parallel flash over its pins.
// Assumes flash pins are sampled via two-stage synchronisers; one user
// request at a time on a valid/ready handshake.
`timescale 1ns/1ps
`include "fbmc_consts.vh"

// Summary of operation
// - Read with select and output gate low, write strobe high.
// - Command writes pulse strobe and select low, output gate high.
// - Host flags a program or erase cut short by core reset as needing restart.
// - Host waits out release-to-read time and busy/ready high before reading.
// - Host writes reset command to leave identification mode.
module fbmc_flash_host #(
    parameter ADDR_W = 19,
    parameter DATA_W = 8,
    parameter RESET_PULSE_CYC = `FBMC_CYC(`FBMC_RESET_PULSE_MIN_NS),
    parameter RELEASE_CYC = `FBMC_CYC(`FBMC_RESET_RELEASE_TO_READ_NS)
) (
    // Clock and reset.
    input wire core_clk,
    input wire resetn,
    // User request port.
    input wire reqValid,
    output wire reqReady,
    input wire [2:0] reqOp,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [DATA_W-1:0] reqData,
    // User answer port.
    output reg rspValid,
    output reg [DATA_W-1:0] rspData,
    output reg opRestartNeeded,
    // Flash pins.
    output reg flashSelectN,
    output reg flashGateN,
    output reg flashStrobeN,
    output reg flashResetN,
    output reg [ADDR_W-1:0] flashAddr,
    input wire [DATA_W-1:0] dataLinesIn,
    output reg [DATA_W-1:0] dataLinesOut,
    output reg dataLinesOeN,
    input wire busyReadyOut
);

    localparam ACC_CYC = `FBMC_CYC(`FBMC_ACCESS_NS);
    localparam WR_CYC = `FBMC_CYC(`FBMC_WRITE_PULSE_NS);
    localparam SU_CYC = `FBMC_CYC(`FBMC_SETUP_NS);
    localparam CNT_W = 16;

    // Controller states.
    localparam ST_IDLE = 3'h0;
    localparam ST_RD = 3'h1;
    localparam ST_WR_SU = 3'h2;
    localparam ST_WR = 3'h3;
    localparam ST_WR_HOLD = 3'h4;
    localparam ST_BUSY = 3'h5;
    localparam ST_RST = 3'h6;
    localparam ST_RST_REL = 3'h7;

    reg [2:0] state_reg;
    reg [CNT_W-1:0] cnt_reg;
    reg [2:0] step_reg;
    reg [2:0] nSteps_reg;
    reg [2:0] op_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] data_reg;
    reg embedded_reg;
    reg rb1_reg;
    reg rb2_reg;
    reg [DATA_W-1:0] din1_reg;
    reg [DATA_W-1:0] din2_reg;
    reg [ADDR_W-1:0] cycAddr;
    reg [DATA_W-1:0] cycData;

    assign reqReady = (state_reg == ST_IDLE);

    // Command cycle table: unlock pair, command byte, then target cycles.
    // Unlock addresses carry zeros above bit 11, which the flash ignores.
    always @*
    begin
        cycAddr = {{(ADDR_W-12){1'b0}}, `FBMC_UNLOCK_ADDR1};
        cycData = `FBMC_UNLOCK_DATA1;
        if (op_reg == `FBMC_OP_RESET_CMD)
        begin
            cycData = `FBMC_CMD_RESET;
        end
        else if (step_reg == 3'h1 || step_reg == 3'h4)
        begin
            cycAddr = {{(ADDR_W-12){1'b0}}, `FBMC_UNLOCK_ADDR2};
            cycData = `FBMC_UNLOCK_DATA2;
        end
        else if (step_reg == 3'h2)
        begin
            case (op_reg)
                `FBMC_OP_PROGRAM: cycData = `FBMC_CMD_PROGRAM;
                `FBMC_OP_ID_READ: cycData = `FBMC_CMD_ID;
                default: cycData = `FBMC_CMD_ERASE_SETUP;
            endcase
        end
        else if (step_reg == 3'h3 && op_reg == `FBMC_OP_PROGRAM)
        begin
            cycAddr = addr_reg;
            cycData = data_reg;
        end
        else if (step_reg == 3'h5)
        begin
            if (op_reg == `FBMC_OP_SECTOR_ERASE)
            begin
                cycAddr = addr_reg; // Upper bits select the sector.
                cycData = `FBMC_CMD_SECTOR_ERASE;
            end
            else
            begin
                cycData = `FBMC_CMD_CHIP_ERASE;
            end
        end
    end

    // Pin inputs cross into the clock domain through two flip-flops.
    always @(posedge core_clk)
    begin
        rb1_reg <= busyReadyOut;
        rb2_reg <= rb1_reg;
        din1_reg <= dataLinesIn;
        din2_reg <= din1_reg;
    end

    // Main sequencer: one bus cycle at a time, all pins from flip-flops.
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_reg <= ST_RST; // Hold the flash in reset with us.
            cnt_reg <= {CNT_W{1'b0}};
            step_reg <= 3'h0;
            nSteps_reg <= 3'h0;
            op_reg <= `FBMC_OP_READ;
            addr_reg <= {ADDR_W{1'b0}};
            data_reg <= {DATA_W{1'b0}};
            // The embedded flag rides through reset so the reset state can
            // still see that a program or erase was cut short.
            rspValid <= 1'b0;
            rspData <= {DATA_W{1'b0}};
            opRestartNeeded <= 1'b0;
            flashSelectN <= 1'b1;
            flashGateN <= 1'b1;
            flashStrobeN <= 1'b1;
            flashResetN <= 1'b0;
            flashAddr <= {ADDR_W{1'b0}};
            dataLinesOut <= {DATA_W{1'b0}};
            dataLinesOeN <= 1'b1;
        end
        else
        begin
            rspValid <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    // Deselected with reset high leaves the flash in standby.
                    flashSelectN <= 1'b1;
                    flashGateN <= 1'b1;
                    flashStrobeN <= 1'b1;
                    dataLinesOeN <= 1'b1;
                    if (reqValid)
                    begin
                        op_reg <= reqOp;
                        addr_reg <= reqAddr;
                        data_reg <= reqData;
                        step_reg <= 3'h0;
                        cnt_reg <= {CNT_W{1'b0}};
                        case (reqOp)
                            `FBMC_OP_READ, `FBMC_OP_ID_READ:
                            begin
                                if (reqOp == `FBMC_OP_ID_READ)
                                begin
                                    nSteps_reg <= 3'h3;
                                    state_reg <= ST_WR_SU;
                                end
                                else
                                begin
                                    // No command needed for array reads.
                                    flashAddr <= reqAddr;
                                    flashSelectN <= 1'b0;
                                    flashGateN <= 1'b0;
                                    state_reg <= ST_RD;
                                end
                            end
                            `FBMC_OP_PROGRAM:
                            begin
                                nSteps_reg <= 3'h4;
                                state_reg <= ST_WR_SU;
                            end
                            `FBMC_OP_SECTOR_ERASE, `FBMC_OP_CHIP_ERASE:
                            begin
                                nSteps_reg <= 3'h6;
                                state_reg <= ST_WR_SU;
                            end
                            `FBMC_OP_RESET_CMD:
                            begin
                                nSteps_reg <= 3'h1;
                                state_reg <= ST_WR_SU;
                            end
                            default:
                            begin
                                flashResetN <= 1'b0;
                                state_reg <= ST_RST;
                            end
                        endcase
                    end
                end
                ST_RD:
                begin
                    // Flash drives data only while the gate is low.
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == ACC_CYC + 2)
                    begin
                        // Two extra cycles cover the input synchroniser.
                        rspData <= din2_reg;
                        // Id reads answer once, after the trailing reset byte.
                        rspValid <= (op_reg != `FBMC_OP_ID_READ);
                        flashGateN <= 1'b1;
                        flashSelectN <= 1'b1;
                        if (op_reg == `FBMC_OP_ID_READ)
                        begin
                            // Leave identification mode with a reset byte.
                            op_reg <= `FBMC_OP_RESET_CMD;
                            nSteps_reg <= 3'h1;
                            step_reg <= 3'h0;
                            cnt_reg <= {CNT_W{1'b0}};
                            state_reg <= ST_WR_SU;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_WR_SU:
                begin
                    // Address and data settle with gate high before strobe.
                    flashGateN <= 1'b1;
                    flashSelectN <= 1'b0;
                    flashAddr <= cycAddr;
                    dataLinesOut <= cycData;
                    dataLinesOeN <= 1'b0;
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg >= SU_CYC)
                    begin
                        flashStrobeN <= 1'b0;
                        cnt_reg <= {CNT_W{1'b0}};
                        state_reg <= ST_WR;
                    end
                end
                ST_WR:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg >= WR_CYC)
                    begin
                        flashStrobeN <= 1'b1; // Data latched on this edge.
                        cnt_reg <= {CNT_W{1'b0}};
                        state_reg <= ST_WR_HOLD;
                    end
                end
                ST_WR_HOLD:
                begin
                    // Strict step order; the flash aborts on any slip.
                    flashSelectN <= 1'b1;
                    dataLinesOeN <= 1'b1;
                    cnt_reg <= {CNT_W{1'b0}};
                    if (step_reg + 3'h1 < nSteps_reg)
                    begin
                        step_reg <= step_reg + 3'h1;
                        state_reg <= ST_WR_SU;
                    end
                    else if (op_reg == `FBMC_OP_ID_READ)
                    begin
                        // Address 0 maker code, address 1 device code.
                        flashAddr <= addr_reg[0] ? `FBMC_ID_DEVICE_ADDR :
                            `FBMC_ID_MAKER_ADDR;
                        flashSelectN <= 1'b0;
                        flashGateN <= 1'b0;
                        state_reg <= ST_RD;
                    end
                    else if (op_reg == `FBMC_OP_RESET_CMD)
                    begin
                        rspValid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        // Wait out the synchroniser before trusting busy.
                        embedded_reg <= 1'b1;
                        opRestartNeeded <= 1'b0;
                        state_reg <= ST_BUSY;
                    end
                end
                ST_BUSY:
                begin
                    // Reset commands are pointless now, so none are sent.
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg > ACC_CYC && rb2_reg)
                    begin
                        embedded_reg <= 1'b0;
                        rspValid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RST:
                begin
                    // An interrupted program or erase must be redone.
                    flashResetN <= 1'b0;
                    flashSelectN <= 1'b1;
                    flashGateN <= 1'b1;
                    flashStrobeN <= 1'b1;
                    dataLinesOeN <= 1'b1;
                    if (embedded_reg)
                    begin
                        opRestartNeeded <= 1'b1;
                    end
                    embedded_reg <= 1'b0;
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg >= RESET_PULSE_CYC)
                    begin
                        flashResetN <= 1'b1;
                        cnt_reg <= {CNT_W{1'b0}};
                        state_reg <= ST_RST_REL;
                    end
                end
                ST_RST_REL:
                begin
                    // Release-to-read time and busy high both gate the exit.
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg >= RELEASE_CYC + 2 && rb2_reg)
                    begin
                        rspValid <= (op_reg == `FBMC_OP_HW_RESET);
                        op_reg <= `FBMC_OP_READ;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // fbmc_flash_host

// >>> fbmc_flash_host_asserts.sv
// Concurrent checks on the pins of the parallel flash host controller.
// Sees only top-level ports; bound into every controller instance.
`timescale 1ns/1ps
module fbmc_flash_host_asserts #(
    parameter RESET_PULSE_CYC = 50
) (
    // Clock and reset.
    input wire core_clk,
    input wire resetn,
    // Request side.
    input wire reqReady,
    // Flash pins.
    input wire flashSelectN,
    input wire flashGateN,
    input wire flashStrobeN,
    input wire flashResetN,
    input wire dataLinesOeN,
    input wire busyReadyOut
);
    integer lowCnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Counts edges with flash reset low; a counter avoids long repetitions.
    always @(posedge core_clk)
    begin
        if (!resetn || flashResetN)
            lowCnt <= 0;
        else
            lowCnt <= lowCnt + 1;
    end

    a_read_strobe_high:
        assert property (!flashGateN |-> flashStrobeN && !flashSelectN)
        else $error("Read cycle without select or with strobe low.");
    a_write_gate_high:
        assert property (!flashStrobeN |->
            flashGateN && !flashSelectN && !dataLinesOeN)
        else $error("Write strobe low with gate low or no data drive.");
    a_read_no_drive:
        assert property (!flashGateN |-> dataLinesOeN)
        else $error("Host drives data lines while flash outputs.");
    a_reset_pins:
        assert property (disable iff (1'b0)
            !resetn |=> !flashResetN && flashSelectN && dataLinesOeN)
        else $error("Flash pins not parked during reset.");
    a_reset_width:
        assert property ($rose(flashResetN) |-> lowCnt >= RESET_PULSE_CYC)
        else $error("Flash reset pulse shorter than minimum.");
    a_release_wait:
        assert property ($rose(flashResetN) |-> flashGateN [*2])
        else $error("Read started too soon after reset release.");
    a_cmd_when_ready:
        assert property ($fell(flashStrobeN) |->
            busyReadyOut && $past(busyReadyOut, 2))
        else $error("Command written while flash busy.");
    a_idle_standby:
        assert property (reqReady |->
            flashSelectN && flashStrobeN && flashResetN)
        else $error("Flash not in standby while idle.");
endmodule // fbmc_flash_host_asserts

bind fbmc_flash_host fbmc_flash_host_asserts #(
    .RESET_PULSE_CYC(RESET_PULSE_CYC)
) fbmc_flash_host_asserts_inst (
    .core_clk(core_clk), .resetn(resetn), .reqReady(reqReady),
    .flashSelectN(flashSelectN), .flashGateN(flashGateN),
    .flashStrobeN(flashStrobeN), .flashResetN(flashResetN),
    .dataLinesOeN(dataLinesOeN), .busyReadyOut(busyReadyOut)
);

// >>> fbmc_flash_model.sv
// Behavioural byte-wide flash: array, command decoder, id codes, busy.
// Assumes host pins change just after core clock edges.
`timescale 1ns/1ps
`include "fbmc_consts.vh"
module fbmc_flash_model #(
    parameter [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
    parameter [7:0] DEVICE_CODE = 8'h5a, // Arbitrary value.
    parameter PROG_CYC = 20,
    parameter ERASE_CYC = 40,
    parameter READY_CYC = 6
) (
    // Sampling clock.
    input wire clk,
    // Control pins, active low.
    input wire selectN,
    input wire gateN,
    input wire strobeN,
    input wire resetN,
    // Address and host side of the data lines.
    input wire [18:0] addr,
    input wire [7:0] hostData,
    input wire hostOeN,
    // Resolved data lines and busy/ready.
    output wire [7:0] lineLevel,
    output wire busyReadyOut
);
    reg [7:0] mem [0:524287];
    reg [2:0] stepReg = 3'h0; // Power-up in array read.
    reg idModeReg = 1'b0;
    reg prevStrobe = 1'b1;
    reg [7:0] pat = 8'ha5;
    reg [1:0] pendKind = 2'h0;
    reg [18:0] pendAddr;
    reg [7:0] pendData;
    integer busyCnt = 0;
    integer i;
    wire [11:0] cmdA = addr[11:0];
    wire devDrive = !selectN && !gateN && resetN;
    wire [7:0] rdVal = !idModeReg ? mem[addr] :
        (addr[1:0] == 2'h0 ? MAKER_CODE : DEVICE_CODE);

    // Released lines show a changing pattern so stale data never passes.
    assign lineLevel = devDrive ? rdVal : (!hostOeN ? hostData : pat);
    assign busyReadyOut = (busyCnt == 0);

    initial
    begin
        for (i = 0; i < 524288; i = i + 1)
            mem[i] = 8'hff;
    end

    // Commands latch on the strobe rising edge with gate high.
    always @(posedge clk)
    begin
        pat <= ~pat;
        prevStrobe <= strobeN;
        if (!resetN)
        begin
            stepReg <= 3'h0;
            idModeReg <= 1'b0;
            pendKind <= 2'h0; // Aborted work is lost.
            if (busyCnt > READY_CYC)
                busyCnt <= READY_CYC; // Busy until internal reset.
            else if (busyCnt != 0)
                busyCnt <= busyCnt - 1;
        end
        else if (busyCnt != 0)
        begin
            busyCnt <= busyCnt - 1; // Runs deselected; commands ignored.
            if (busyCnt == 1 && pendKind == 2'h1)
                mem[pendAddr] = mem[pendAddr] & pendData;
            if (busyCnt == 1 && pendKind[1])
                for (i = 0; i < 524288; i = i + 1)
                    if (pendKind[0] || i[18:16] == pendAddr[18:16])
                        mem[i] = 8'hff;
        end
        else if (!prevStrobe && strobeN && !selectN && gateN)
        begin
            stepReg <= 3'h0; // Mismatch drops the sequence.
            if (stepReg == 3'h3)
            begin
                pendKind <= 2'h1;
                pendAddr <= addr;
                pendData <= hostData;
                busyCnt <= PROG_CYC;
            end
            else if (stepReg == 3'h6 && (hostData == `FBMC_CMD_CHIP_ERASE
                || hostData == `FBMC_CMD_SECTOR_ERASE))
            begin
                pendKind <= {1'b1, hostData == `FBMC_CMD_CHIP_ERASE};
                pendAddr <= addr;
                busyCnt <= ERASE_CYC;
            end
            else if (stepReg == 3'h2 && cmdA == `FBMC_UNLOCK_ADDR1
                && hostData == `FBMC_CMD_ID)
                idModeReg <= 1'b1;
            else if (stepReg == 3'h2 && cmdA == `FBMC_UNLOCK_ADDR1
                && hostData == `FBMC_CMD_PROGRAM)
                stepReg <= 3'h3;
            else if (stepReg == 3'h2 && cmdA == `FBMC_UNLOCK_ADDR1
                && hostData == `FBMC_CMD_ERASE_SETUP)
                stepReg <= 3'h4;
            else if ((stepReg == 3'h0 || stepReg == 3'h4)
                && cmdA == `FBMC_UNLOCK_ADDR1 && hostData == `FBMC_UNLOCK_DATA1)
                stepReg <= stepReg + 3'h1;
            else if ((stepReg == 3'h1 || stepReg == 3'h5)
                && cmdA == `FBMC_UNLOCK_ADDR2 && hostData == `FBMC_UNLOCK_DATA2)
                stepReg <= stepReg + 3'h1;
            else
                idModeReg <= 1'b0; // Reset byte or bad cycle.
        end
    end
endmodule // fbmc_flash_model

// >>> fbmc_flash_host_test.sv
// Self-checking bench for the flash host controller and a flash model.
// Expected answers queue up in the driver; a monitor matches them.
`timescale 1ns/1ps
`include "fbmc_consts.vh"
module fbmc_flash_host_test;
    localparam [7:0] MAKER = 8'h3c; // Arbitrary identification value.
    localparam [7:0] DEVICE = 8'h5a; // Arbitrary identification value.
    localparam [9:0] NODATA = 10'h200;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg reqValid = 1'b0;
    reg [2:0] reqOp = 3'h0;
    reg [18:0] reqAddr = 19'h0;
    reg [7:0] reqData = 8'h0;
    wire reqReady, rspValid, opRestartNeeded, busyReadyOut, dataLinesOeN;
    wire flashSelectN, flashGateN, flashStrobeN, flashResetN;
    wire [7:0] rspData, dataLinesOut, dataLinesIn;
    wire [18:0] flashAddr;
    integer failures = 0;
    integer checks_done = 0;
    integer seed = 8;
    integer k;
    reg [31:0] rnd;
    reg [18:0] a;
    logic [9:0] expQ[$];
    logic [7:0] refMem [logic [18:0]];
    logic [18:0] used[$];

    fbmc_flash_host #(.RESET_PULSE_CYC(2), .RELEASE_CYC(2))
    fbmc_flash_host_inst (
        .core_clk(core_clk), .resetn(resetn), .reqValid(reqValid),
        .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
        .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
        .opRestartNeeded(opRestartNeeded), .flashSelectN(flashSelectN),
        .flashGateN(flashGateN), .flashStrobeN(flashStrobeN),
        .flashResetN(flashResetN), .flashAddr(flashAddr),
        .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataLinesOeN(dataLinesOeN), .busyReadyOut(busyReadyOut));
    fbmc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    fbmc_flash_model_inst (
        .clk(core_clk), .selectN(flashSelectN), .gateN(flashGateN),
        .strobeN(flashStrobeN), .resetN(flashResetN), .addr(flashAddr),
        .hostData(dataLinesOut), .hostOeN(dataLinesOeN),
        .lineLevel(dataLinesIn), .busyReadyOut(busyReadyOut));

    always #5 core_clk = ~core_clk;

    task check(input string what, input logic [7:0] seen, input logic [7:0] ex);
        begin
            checks_done = checks_done + 1;
            if (seen !== ex)
            begin
                failures = failures + 1;
                $display("[FAIL] %s expected %h seen %h", what, ex, seen);
            end
        end
    endtask

    function [7:0] expAt(input [18:0] ad);
        expAt = refMem.exists(ad) ? refMem[ad] : 8'hff;
    endfunction

    // Holds the request until the edge that takes it, then releases it.
    task op(input [2:0] o, input [18:0] ad, input [7:0] dt, input [9:0] note);
        integer n;
        begin
            n = 0;
            if (note[9])
                expQ.push_back(note);
            reqOp <= o;
            reqAddr <= ad;
            reqData <= dt;
            reqValid <= 1'b1;
            do
            begin
                @(posedge core_clk);
                n = n + 1;
            end
            while (reqReady !== 1'b1 && n < 20000);
            if (n >= 20000)
                failures = failures + 1;
            reqValid <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    task rd(input [18:0] ad);
        op(`FBMC_OP_READ, ad, 8'h00, {2'b11, expAt(ad)});
    endtask

    task prog(input [18:0] ad, input [7:0] dt);
        begin
            op(`FBMC_OP_PROGRAM, ad, dt, NODATA);
            refMem[ad] = expAt(ad) & dt;
            used.push_back(ad);
        end
    endtask

    task erase(input [2:0] o, input [18:0] ad);
        begin
            op(o, ad, 8'h00, NODATA);
            foreach (used[j])
                if (o == `FBMC_OP_CHIP_ERASE || used[j][18:16] == ad[18:16])
                    refMem[used[j]] = 8'hff;
        end
    endtask

    // Waits until every noted answer has arrived and the port is idle.
    task endTest(input string nm);
        integer n;
        begin
            n = 0;
            while ((expQ.size() != 0 || reqReady !== 1'b1) && n < 20000)
            begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n >= 20000)
                failures = failures + 1;
            $display("test %s done", nm);
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // Matches each answer with the oldest note; stray answers fail.
    always @(posedge core_clk)
    begin
        if (rspValid === 1'b1 && expQ.size() == 0)
            check("unexpected answer", 8'h01, 8'h00);
        else if (rspValid === 1'b1 && expQ[0][8])
        begin
            check("rspData", rspData, expQ[0][7:0]);
            void'(expQ.pop_front());
        end
        else if (rspValid === 1'b1)
            void'(expQ.pop_front());
    end

    // A hang costs a mismatch and ends the run the usual way.
    initial
    begin
        #800000;
        failures = failures + 1;
        wrap_up;
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(19'h12345); // Erased array readable without any command.
        endTest("power-up read");
        for (k = 0; k < 4; k = k + 1)
        begin
            rnd = $random(seed);
            a = rnd[18:0];
            prog(a, rnd[26:19]);
            rd(a);
        end
        prog(19'h7ffff, 8'h00);
        rd(19'h7ffff);
        endTest("program");
        op(`FBMC_OP_ID_READ, 19'h00000, 8'h00, {2'b11, MAKER});
        op(`FBMC_OP_ID_READ, 19'h00001, 8'h00, {2'b11, DEVICE});
        rd(used[0]);
        op(`FBMC_OP_RESET_CMD, 19'h00000, 8'h00, NODATA);
        rd(used[1]);
        endTest("identification");
        erase(`FBMC_OP_SECTOR_ERASE, used[0]);
        foreach (used[j])
            rd(used[j]);
        erase(`FBMC_OP_CHIP_ERASE, 19'h00000);
        rd(used[1]);
        op(`FBMC_OP_HW_RESET, 19'h00000, 8'h00, NODATA);
        rd(used[0]);
        endTest("erase and reset");
        // Core reset in mid program: byte lost, restart flagged.
        a = 19'h01234;
        op(`FBMC_OP_PROGRAM, a, 8'h3c, 10'h000);
        k = 0;
        while (busyReadyOut !== 1'b0 && k < 1000)
        begin
            @(posedge core_clk);
            k = k + 1;
        end
        if (k >= 1000)
            failures = failures + 1;
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(a);
        check("restart flag", {7'h00, opRestartNeeded}, 8'h01);
        prog(a, 8'h3c);
        rd(a);
        endTest("reset in program");
        check("restart flag", {7'h00, opRestartNeeded}, 8'h00);
        wrap_up;
    end
endmodule // fbmc_flash_host_test
